//--- rtl/ebus_defs.svh
`ifndef EBUS_DEFS_SVH
`define EBUS_DEFS_SVH

`define ADDR_MAX     24
`define BURST_LSB    4
`define TIME_W       4
`define FIFO_DEPTH   8
`define ALE_W_RST    4'h1
`define FETCH_W_RST  4'h2
`define RDWR_W_RST   4'h2
`define HOLD_W_RST   4'h0
`define WIDTH16_RST  1'b0

`endif

//--- rtl/ebus_pkg.sv
`include "ebus_defs.svh"

package ebus_pkg;

  typedef enum logic [1:0] {
    OP_CODE  = 2'h0,
    OP_READ  = 2'h1,
    OP_WRITE = 2'h2
  } op_kind_e;

  typedef struct packed {
    op_kind_e                  kind;
    logic                      word;
    logic [`ADDR_MAX-1:0]      addr;
    logic [15:0]               wdata;
  } req_s;

  typedef struct packed {
    logic [`TIME_W-1:0]        ale;
    logic [`TIME_W-1:0]        fetch;
    logic [`TIME_W-1:0]        rdwr;
    logic [`TIME_W-1:0]        hold;
  } timing_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ALE  = 4'b0010,
    ST_STRB = 4'b0100,
    ST_HOLD = 4'b1000
  } state_e;

endpackage : ebus_pkg

//--- rtl/ebus_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module ebus_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             srst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("ebus_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end

endmodule : ebus_fifo

`default_nettype wire

//--- rtl/ebus_phase_timer.sv
`timescale 1ns/10ps
`default_nettype none

module ebus_phase_timer #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);

  if (W < 1) begin : g_bad_width
    $error("ebus_phase_timer needs a counter of at least one bit");
  end

  logic [W-1:0] cnt_q;

  // A loaded value of n gives a phase of n plus one cycles.
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign done = cnt_q == '0;

endmodule : ebus_phase_timer

`default_nettype wire

//--- rtl/ebus_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "ebus_defs.svh"

module ebus_ctrl #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Core access requests.
  input  wire logic                  req_valid,
  input  wire ebus_pkg::req_s        req,
  output logic                       req_ready,
  // Read answers.
  output logic                       rsp_valid,
  output logic [15:0]                rsp_data,
  // Configuration and straps.
  input  wire logic                  width_strap,
  input  wire logic                  onchip_code_select_pin_n,
  input  wire logic                  cfg_width_wr,
  input  wire logic                  cfg_width_16,
  input  wire logic [4:0]            cfg_addr_lines,
  input  wire ebus_pkg::timing_s     cfg_timing,
  // Status.
  output logic                       bus_is_16,
  output logic                       boot_internal,
  output logic                       bus_used,
  // External bus pins.
  output logic [`ADDR_MAX-1:0]       addr_o,
  output logic [`ADDR_MAX-1:0]       addr_oe,
  output logic                       ale,
  output logic                       code_fetch_strobe_n,
  output logic                       rd_n,
  output logic                       low_byte_write_strobe_n,
  output logic                       high_byte_write_strobe_n,
  input  wire logic                  wait_req,
  input  wire logic [15:0]           data_i,
  output logic [15:0]                data_o,
  output logic                       data_oe
);
  import ebus_pkg::*;

  if (FIFO_DEPTH < 2) begin : g_bad_fifo
    $error("ebus_ctrl needs a request FIFO of at least two words");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  function automatic logic [`ADDR_MAX-1:0] eff_addr(input req_s r);
    return r.word ? {r.addr[`ADDR_MAX-1:1], 1'b0} : r.addr;
  endfunction : eff_addr

  function automatic logic burst_ok(input logic lc, input req_s r,
                                    input logic [`ADDR_MAX-1:`BURST_LSB] up);
    return lc && r.kind == OP_CODE && r.addr[`ADDR_MAX-1:`BURST_LSB] == up;
  endfunction : burst_ok

  // Places write data on the lanes that the strobes qualify.
  function automatic logic [15:0] lanes(input req_s r, input logic b16, input logic sub);
    if (!b16) begin
      return {8'h00, sub ? r.wdata[15:8] : r.wdata[7:0]};
    end else if (r.word) begin
      return r.wdata;
    end
    return {r.wdata[7:0], r.wdata[7:0]};
  endfunction : lanes

  function automatic logic [`ADDR_MAX-1:0] line_mask(input logic [4:0] n);
    logic [`ADDR_MAX-1:0] m;
    m = '0;
    for (int i = 0; i < `ADDR_MAX; i++) begin
      m[i] = i < int'(n);
    end
    return m;
  endfunction : line_mask

  // ---------------------------------------------------------------
  // Request buffer
  // ---------------------------------------------------------------

  logic                           fifo_valid;
  logic [$bits(req_s)-1:0]        fifo_raw;
  req_s                           fifo_out;
  logic                           pop;

  ebus_fifo #(
    .WIDTH ($bits(req_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   (req),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_raw)
  );

  assign fifo_out = req_s'(fifo_raw);

  // ---------------------------------------------------------------
  // Width and boot straps
  // ---------------------------------------------------------------

  logic                           strap_done_q;
  logic                           bus16_q;
  logic                           boot_int_q;
  logic                           bus_used_q;

  // Straps are caught on the first edge after reset release.
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_done_q <= 1'b0;
      bus16_q      <= `WIDTH16_RST;
      boot_int_q   <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      bus16_q      <= width_strap;
      boot_int_q   <= !onchip_code_select_pin_n;
    end else if (cfg_width_wr && !bus_used_q) begin
      bus16_q      <= cfg_width_16;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------

  state_e                         state_q;
  state_e                         state_d;
  req_s                           cur_q;
  logic                           sub_q;
  logic [`ADDR_MAX-1:0]           bus_addr_q;
  logic                           last_code_q;
  logic [`ADDR_MAX-1:`BURST_LSB]  upper_q;
  logic                           t_load;
  logic [`TIME_W-1:0]             t_val;
  logic                           t_done;
  logic                           fin;
  logic                           step;
  logic                           strb_end;

  ebus_phase_timer #(
    .W (`TIME_W)
  ) u_timer (
    .clk   (clk),
    .srst  (srst),
    .load  (t_load),
    .value (t_val),
    .done  (t_done)
  );

  assign strb_end = state_q == ST_STRB && t_done && !wait_req;

  always_comb begin
    state_d = state_q;
    pop     = 1'b0;
    t_load  = 1'b0;
    t_val   = '0;
    fin     = 1'b0;
    step    = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (fifo_valid && strap_done_q) begin
          pop    = 1'b1;
          t_load = 1'b1;
          if (burst_ok(last_code_q, fifo_out, upper_q)) begin
            state_d = ST_STRB;
            t_val   = cfg_timing.fetch;
          end else begin
            state_d = ST_ALE;
            t_val   = cfg_timing.ale;
          end
        end
      end
      ST_ALE: begin
        if (t_done) begin
          state_d = ST_STRB;
          t_load  = 1'b1;
          t_val   = cur_q.kind == OP_CODE ? cfg_timing.fetch : cfg_timing.rdwr;
        end
      end
      ST_STRB: begin
        if (strb_end) begin
          if (cur_q.kind == OP_WRITE) begin
            state_d = ST_HOLD;
            t_load  = 1'b1;
            t_val   = cfg_timing.hold;
          end else begin
            fin = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        fin = t_done;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (fin) begin
      // A word on an 8-bit bus takes a second byte cycle at the odd address.
      if (!bus16_q && cur_q.word && !sub_q) begin
        step   = 1'b1;
        t_load = 1'b1;
        if (burst_ok(cur_q.kind == OP_CODE, cur_q, bus_addr_q[`ADDR_MAX-1:`BURST_LSB])) begin
          state_d = ST_STRB;
          t_val   = cfg_timing.fetch;
        end else begin
          state_d = ST_ALE;
          t_val   = cfg_timing.ale;
        end
      end else begin
        state_d = ST_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur_q      <= '0;
      sub_q      <= 1'b0;
      bus_addr_q <= '0;
      data_o     <= '0;
    end else if (pop) begin
      cur_q      <= fifo_out;
      sub_q      <= 1'b0;
      bus_addr_q <= eff_addr(fifo_out);
      data_o     <= lanes(fifo_out, bus16_q, 1'b0);
    end else if (step) begin
      sub_q      <= 1'b1;
      bus_addr_q <= {bus_addr_q[`ADDR_MAX-1:1], 1'b1};
      data_o     <= lanes(cur_q, bus16_q, 1'b1);
    end
  end

  // Tracks the upper address that the external latch still holds.
  always_ff @(posedge clk) begin
    if (srst) begin
      last_code_q <= 1'b0;
      upper_q     <= '0;
      bus_used_q  <= 1'b0;
    end else begin
      if (state_q == ST_ALE) begin
        last_code_q <= cur_q.kind == OP_CODE;
        upper_q     <= bus_addr_q[`ADDR_MAX-1:`BURST_LSB];
      end
      if (state_q != ST_IDLE) begin
        bus_used_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read capture
  // ---------------------------------------------------------------

  logic [15:0]                    rdata_q;
  logic                           rsp_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= '0;
      rsp_q   <= 1'b0;
    end else begin
      rsp_q <= fin && !step && cur_q.kind != OP_WRITE;
      if (strb_end && cur_q.kind != OP_WRITE) begin
        if (bus16_q && cur_q.word) begin
          rdata_q <= data_i;
        end else if (bus16_q) begin
          rdata_q <= {8'h00, bus_addr_q[0] ? data_i[15:8] : data_i[7:0]};
        end else if (sub_q) begin
          rdata_q <= {data_i[7:0], rdata_q[7:0]};
        end else begin
          rdata_q <= {8'h00, data_i[7:0]};
        end
      end
    end
  end

  assign rsp_valid = rsp_q;
  assign rsp_data  = rdata_q;

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------

  logic                           wr_phase;

  assign wr_phase = state_q == ST_STRB && cur_q.kind == OP_WRITE;

  assign bus_is_16     = bus16_q;
  assign boot_internal = boot_int_q;
  assign bus_used      = bus_used_q;
  assign addr_o        = bus_addr_q;
  assign addr_oe       = line_mask(cfg_addr_lines);
  assign ale           = state_q == ST_ALE;

  assign code_fetch_strobe_n = !(state_q == ST_STRB && cur_q.kind == OP_CODE);
  assign rd_n                = !(state_q == ST_STRB && cur_q.kind == OP_READ);

  assign low_byte_write_strobe_n =
    !(wr_phase && (!bus16_q || cur_q.word || !bus_addr_q[0]));
  assign high_byte_write_strobe_n =
    !(wr_phase && bus16_q && (cur_q.word || bus_addr_q[0]));

  assign data_oe = cur_q.kind == OP_WRITE && (state_q == ST_STRB || state_q == ST_HOLD);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_hold_phase;
    data_oe && low_byte_write_strobe_n && high_byte_write_strobe_n;
  endsequence

  sequence s_strobe_low;
    !code_fetch_strobe_n || !rd_n || !low_byte_write_strobe_n || !high_byte_write_strobe_n;
  endsequence

  a_strap_width: assert property (!srst && !strap_done_q |=> bus16_q == $past(width_strap)
      && boot_internal == !$past(onchip_code_select_pin_n))
    else $error("width or boot strap not caught at reset release");
  a_width_lock: assert property (bus_used_q |=> $stable(bus16_q))
    else $error("bus width changed after external bus use");
  a_line_count: assert property ($countones(addr_oe)
      == (cfg_addr_lines > 5'd24 ? 24 : int'(cfg_addr_lines)))
    else $error("driven address line count wrong");
  a_read_after_ale: assert property ($fell(rd_n) |-> $past(ale))
    else $error("read strobe without preceding latch pulse");
  a_fetch_code: assert property (!code_fetch_strobe_n |-> cur_q.kind == OP_CODE)
    else $error("code fetch strobe outside code read");
  a_one_strobe: assert property ($onehot0({!code_fetch_strobe_n, !rd_n,
      !(low_byte_write_strobe_n && high_byte_write_strobe_n)})
      && !(ale && !(code_fetch_strobe_n && rd_n)))
    else $error("strobes overlap");
  a_high_lane: assert property (!high_byte_write_strobe_n |-> bus16_q)
    else $error("high byte strobe on 8-bit bus");
  a_low_only8: assert property (!bus16_q && wr_phase |-> !low_byte_write_strobe_n)
    else $error("low byte strobe missing on 8-bit write");
  a_wait_hold: assert property (s_strobe_low and wait_req |=> s_strobe_low)
    else $error("cycle ended while wait asserted");
  a_even_word: assert property (state_q != ST_IDLE && cur_q.word && !sub_q
      |-> !addr_o[0])
    else $error("word access at odd address");
  a_ale_width: assert property ($rose(ale) && cfg_timing.ale == '0 |=> !ale)
    else $error("latch pulse longer than programmed");
  a_write_hold: assert property ($rose(low_byte_write_strobe_n) && data_oe
      && cfg_timing.hold == '0 |-> s_hold_phase ##1 !data_oe)
    else $error("write data hold not as programmed");

endmodule : ebus_ctrl

`default_nettype wire

//--- testbench/ext_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module ext_mem_model (
  // Clock and bus set-up of the board.
  input  wire logic        clk,
  input  wire logic        bus16,
  input  wire logic [3:0]  wait_n,
  // Bus pins of the controller.
  input  wire logic [23:0] addr_o,
  input  wire logic [23:0] addr_oe,
  input  wire logic        ale,
  input  wire logic        code_fetch_strobe_n,
  input  wire logic        rd_n,
  input  wire logic        low_byte_write_strobe_n,
  input  wire logic        high_byte_write_strobe_n,
  input  wire logic [15:0] data_o,
  input  wire logic        data_oe,
  // Answers to the controller.
  output logic [15:0]      data_i,
  output logic             wait_req
);
  logic [7:0]  mem [4096];
  logic [7:0]  up_q;
  logic [3:0]  cnt_q;
  logic [15:0] last_q;
  logic [11:0] a;
  logic        rd_en;
  logic        strb;

  assign a = {up_q, addr_o[3:0] & addr_oe[3:0]};
  assign rd_en = !code_fetch_strobe_n || !rd_n;
  assign strb = rd_en || !low_byte_write_strobe_n || !high_byte_write_strobe_n;
  assign wait_req = strb && (cnt_q < wait_n);

  // A released data bus shows the inverse of its last level.
  always_comb begin
    if (!rd_en) begin
      data_i = ~last_q;
    end else if (bus16) begin
      data_i = {mem[{a[11:1], 1'b1}], mem[{a[11:1], 1'b0}]};
    end else begin
      data_i = {~last_q[15:8], mem[a]};
    end
  end

  always_ff @(posedge clk) begin
    last_q <= data_i;
    cnt_q <= strb ? cnt_q + 4'h1 : 4'h0;
    if (ale) begin
      up_q <= addr_o[11:4] & addr_oe[11:4];
    end
    if (!low_byte_write_strobe_n && data_oe) begin
      mem[bus16 ? {a[11:1], 1'b0} : a] <= data_o[7:0];
    end
    if (!high_byte_write_strobe_n && data_oe) begin
      mem[{a[11:1], 1'b1}] <= data_o[15:8];
    end
  end
endmodule : ext_mem_model

`default_nettype wire

//--- testbench/external_memory_bus_tb.sv
`timescale 1ns/10ps
`default_nettype none

module pulse_meter (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic srst,
  // Watched level, count of ended pulses and width of the last one.
  input  wire logic lvl,
  output logic [7:0] cnt,
  output logic [7:0] wid
);
  logic [7:0] run_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      run_q <= 8'h00;
      cnt <= 8'h00;
      wid <= 8'h00;
    end else if (lvl) begin
      run_q <= run_q + 8'h01;
    end else if (run_q != 8'h00) begin
      cnt <= cnt + 8'h01;
      wid <= run_q;
      run_q <= 8'h00;
    end
  end
endmodule : pulse_meter

module external_memory_bus_tb;
  import ebus_pkg::*;
  logic clk = 0, srst = 1, req_valid = 0, width_strap = 0, pin_n = 0, cfg_width_wr = 0;
  logic cfg_width_16 = 0, bus16 = 0;
  logic [4:0] cfg_addr_lines = 5'h18;
  logic [3:0] wait_n = 4'h0;
  req_s req = '0;
  timing_s cfg_timing = '0;
  logic rsp_valid, bus_is_16, boot_internal, bus_used, ale, cf_n, rd_n, wl_n, wh_n;
  logic wait_req, data_oe;
  logic [15:0] rsp_data, data_i, data_o;
  logic [23:0] addr_o, addr_oe;
  logic req_ready;
  logic [7:0] c_ale, w_ale, c_cf, w_cf, c_rd, w_rd, c_wl, w_wl, c_wh, w_wh, c_oe, w_oe;
  int n_fail = 0, n_compared = 0, n_ovl = 0;

  always #2 clk = ~clk;

  ebus_ctrl dut_u (.clk(clk), .srst(srst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .width_strap(width_strap), .onchip_code_select_pin_n(pin_n),
    .cfg_width_wr(cfg_width_wr), .cfg_width_16(cfg_width_16),
    .cfg_addr_lines(cfg_addr_lines), .cfg_timing(cfg_timing), .bus_is_16(bus_is_16),
    .boot_internal(boot_internal), .bus_used(bus_used), .addr_o(addr_o),
    .addr_oe(addr_oe), .ale(ale), .code_fetch_strobe_n(cf_n), .rd_n(rd_n),
    .low_byte_write_strobe_n(wl_n), .high_byte_write_strobe_n(wh_n),
    .wait_req(wait_req), .data_i(data_i), .data_o(data_o), .data_oe(data_oe));
  ext_mem_model mem_u (.clk(clk), .bus16(bus16), .wait_n(wait_n), .addr_o(addr_o),
    .addr_oe(addr_oe), .ale(ale), .code_fetch_strobe_n(cf_n), .rd_n(rd_n),
    .low_byte_write_strobe_n(wl_n), .high_byte_write_strobe_n(wh_n),
    .data_o(data_o), .data_oe(data_oe), .data_i(data_i), .wait_req(wait_req));
  pulse_meter m_ale (.clk(clk), .srst(srst), .lvl(ale), .cnt(c_ale), .wid(w_ale));
  pulse_meter m_cf (.clk(clk), .srst(srst), .lvl(!cf_n), .cnt(c_cf), .wid(w_cf));
  pulse_meter m_rd (.clk(clk), .srst(srst), .lvl(!rd_n), .cnt(c_rd), .wid(w_rd));
  pulse_meter m_wl (.clk(clk), .srst(srst), .lvl(!wl_n), .cnt(c_wl), .wid(w_wl));
  pulse_meter m_wh (.clk(clk), .srst(srst), .lvl(!wh_n), .cnt(c_wh), .wid(w_wh));
  pulse_meter m_oe (.clk(clk), .srst(srst), .lvl(data_oe), .cnt(c_oe), .wid(w_oe));

  // Counts cycles with a strobe beside the latch pulse or two kinds of strobe at once.
  always @(posedge clk) begin
    if (!srst && ((ale && !(cf_n && rd_n && wl_n && wh_n)) ||
        (int'(!cf_n) + int'(!rd_n) + int'(!(wl_n && wh_n)) > 1))) begin
      n_ovl++;
    end
  end

  task automatic end_sim();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input op_kind_e k, input logic w, input logic [23:0] a,
                      input logic [15:0] d);
    int i;
    req_valid <= 1'b1;
    req <= '{k, w, a, d};
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (req_ready === 1'b1) break;
    end
    if (i == 200) begin
      n_fail++;
      end_sim();
    end
  endtask : send

  task automatic rd(input op_kind_e k, input logic w, input logic [23:0] a,
                    input logic [15:0] exp);
    int i;
    send(k, w, a, 16'h0000);
    req_valid <= 1'b0;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (rsp_valid === 1'b1) break;
    end
    if (i == 200) begin
      n_fail++;
      end_sim();
    end
    check(rsp_data, exp);
    @(posedge clk);
  endtask : rd

  task automatic do_reset(input logic strap, input logic sel_n);
    srst <= 1'b1;
    width_strap <= strap;
    pin_n <= sel_n;
    bus16 <= strap;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic cfgw(input logic v);
    cfg_width_16 <= v;
    cfg_width_wr <= 1'b1;
    @(posedge clk);
    cfg_width_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : cfgw

  task automatic t_width8();
    do_reset(1'b0, 1'b0);
    check(bus_is_16, 1'b0);
    check(boot_internal, 1'b1);
    cfg_timing <= '{4'h1, 4'h1, 4'h2, 4'h1};
    send(OP_WRITE, 1'b1, 24'h000401, 16'hc3a5);
    rd(OP_READ, 1'b1, 24'h000400, 16'hc3a5);
    check(c_wl, 8'h02);
    check(c_wh, 8'h00);
    cfg_addr_lines <= 5'h0c;
    repeat (2) @(posedge clk);
    check(addr_oe, 24'h000fff);
    cfg_addr_lines <= 5'h1e;
    repeat (2) @(posedge clk);
    check(addr_oe, 24'hffffff);
    cfg_addr_lines <= 5'h18;
  endtask : t_width8

  task automatic t_width16();
    do_reset(1'b1, 1'b1);
    check(bus_is_16, 1'b1);
    check(boot_internal, 1'b0);
    cfgw(1'b0);
    check(bus_is_16, 1'b0);
    cfgw(1'b1);
    check(bus_is_16, 1'b1);
    check(bus_used, 1'b0);
    send(OP_WRITE, 1'b1, 24'h001235, 16'hbeef);
    rd(OP_READ, 1'b1, 24'h001234, 16'hbeef);
    check({w_wl, w_oe, w_ale}, 24'h030502);
    check({c_wl, c_wh, c_cf}, 24'h010100);
    send(OP_WRITE, 1'b0, 24'h001237, 16'h5a5a);
    rd(OP_READ, 1'b0, 24'h001237, 16'h005a);
    check({c_wl, c_wh, w_rd}, 24'h010203);
    cfgw(1'b0);
    check({bus_used, bus_is_16}, 2'b11);
  endtask : t_width16

  task automatic t_wait();
    wait_n <= 4'h3;
    cfg_timing <= '{4'h1, 4'h1, 4'h0, 4'h1};
    rd(OP_READ, 1'b1, 24'h001234, 16'hbeef);
    check(w_rd, 8'h04);
    wait_n <= 4'h0;
  endtask : t_wait

  task automatic t_code();
    logic [7:0] a0;
    logic [7:0] r0;
    send(OP_WRITE, 1'b1, 24'h002000, 16'h1111);
    send(OP_WRITE, 1'b1, 24'h002002, 16'h2222);
    send(OP_WRITE, 1'b1, 24'h002010, 16'h3333);
    r0 = c_rd;
    rd(OP_CODE, 1'b1, 24'h002000, 16'h1111);
    a0 = c_ale;
    rd(OP_CODE, 1'b1, 24'h002002, 16'h2222);
    check(c_ale - a0, 8'h00);
    check(w_cf, 8'h02);
    rd(OP_CODE, 1'b1, 24'h002010, 16'h3333);
    check(c_ale - a0, 8'h01);
    check({c_rd, c_cf}, {r0, 8'h03});
  endtask : t_code

  task automatic t_fifo();
    int n;
    int j;
    logic full;
    n = 0;
    full = 1'b0;
    cfg_timing <= '{4'h0, 4'h0, 4'h0, 4'h0};
    wait_n <= 4'h8;
    while (!full && n < 20) begin
      req_valid <= 1'b1;
      req <= '{OP_WRITE, 1'b1, 24'h000300 + 24'(2 * n), 16'h1100 + 16'(n)};
      @(posedge clk);
      if (req_ready === 1'b1) n++;
      else full = 1'b1;
    end
    check({full, 1'(n >= 8)}, 2'b11);
    wait_n <= 4'h2;
    for (j = 0; j < n; j++) begin
      rd(OP_READ, 1'b1, 24'h000300 + 24'(2 * j), 16'h1100 + 16'(j));
    end
    wait_n <= 4'h0;
  endtask : t_fifo

  initial begin
    t_width8();
    t_width16();
    t_wait();
    t_code();
    t_fifo();
    check(24'(n_ovl), 24'h000000);
    end_sim();
  end
endmodule : external_memory_bus_tb

`default_nettype wire
